// file: rtl/dd2_regs.svh
// Purpose: Constants of the DDR2 device command interface.
// Assumes: Included by bare name; definitions only.
// Notes: Mode field positions follow the usual DDR2 op-code layout.
//
// Behaviour
// - Bursts are 4 or 8 transfers, chosen by mode programming.
// - Column access latency is 5 or 6 cycles.
// - Posted command delay is 0 to 5 cycles.
// - Read data starts posted delay plus column latency after the read.
// - Write data starts one cycle earlier than read data would.
// - Three bank bits pick one of eight banks per command.
// - Burst order is sequential or interleaved, per programmed burst type.
// - Chip select high at an edge masks every command.
// - Command is decoded from row, column, write strobes and chip select.
// - Inputs sampled on rising CK; read data uses both clock edges.
// - CKE low enters precharge, active power-down or self-refresh.
// - CKE sampled on edges, except self-refresh exit which is asynchronous.
// - Power-down ignores all but clock, ODT, CKE; self-refresh all but CKE.
// - Activate carries 13-bit row; read/write carry column and A10 flag.
// - Precharge with A10 low closes one bank, high closes all.
// - Mode set carries op-code; bank bits choose base or extended register.
// - Registered ODT enables termination unless disabled in extended config.
// - Low strobe covers bits 0-7, high strobe bits 8-15.
// - Extended config bit 10: 0 differential strobes, 1 single-ended.
// - Write bytes whose byte mask is high are discarded.
`ifndef DD2_REGS_SVH
`define DD2_REGS_SVH

// ----------------------------------------------------------------
// Mode register selection by bank address
// ----------------------------------------------------------------
`define DD2_BA_BASE 3'h0
`define DD2_BA_EXT1 3'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DD2_BL_LSB 0
`define DD2_BT_BIT 3
`define DD2_CL_LSB 4
`define DD2_AL_LSB 3
`define DD2_RTT0_BIT 2
`define DD2_RTT1_BIT 6
`define DD2_STROBE_SE_BIT 10
`define DD2_AUTO_PRE_BIT 10

// ----------------------------------------------------------------
// Codes, limits and reset values
// ----------------------------------------------------------------
`define DD2_BL_CODE4 3'h2
`define DD2_BL_CODE8 3'h3
`define DD2_CL_MIN 3'h5
`define DD2_CL_MAX 3'h6
`define DD2_AL_MAX 3'h5
`define DD2_CL_RST 3'h5
`define DD2_AL_RST 3'h0
`define DD2_LAT_SLOTS 11

`endif

// file: rtl/dd2_pkg.sv
// Purpose: Types of the DDR2 device command interface.
// Assumes: Constants live in dd2_regs.svh.
// Notes: Data pins carry one rising and one falling beat per CK cycle.
package dd2_pkg;

   typedef enum logic [2:0] {
      cmd_nop, cmd_mode_set, cmd_refresh, cmd_precharge,
      cmd_activate, cmd_write, cmd_read
   } dd2_cmd_t;

   typedef enum logic [1:0] {pwr_run, pwr_pre_down, pwr_act_down} dd2_pwr_t;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [2:0] ba;
      logic [12:0] addr;
   } dd2_pins_t;

   typedef struct packed {
      logic valid;
      logic is_write;
      logic [2:0] bank;
      logic [12:0] row;
      logic [9:0] col;
   } dd2_slot_t;

   typedef struct packed {
      logic [15:0] rise;
      logic [15:0] fall;
   } dd2_pair_t;

   typedef struct packed {
      logic [1:0] rise;
      logic [1:0] fall;
   } dd2_mask_t;

   typedef struct packed {
      logic pre_down;
      logic act_down;
      logic self_ref;
      logic [7:0] banks_open;
      logic term_on;
      logic diff_strobe;
      logic burst_busy;
   } dd2_status_t;

endpackage

// file: rtl/dd2_device.sv
// Purpose: DDR2 device command decode, latencies, bursts and power modes.
// Assumes: i_ck is the CK/CK# crossing; pins are already in its domain.
// Notes: Status is carried into the i_clock domain by two-flop synchronisers.
`timescale 1ns/1ps
`default_nettype none
`include "dd2_regs.svh"

module dd2_device #(
   parameter int MEM_AW = 14
) (
   // Clocks and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_ck,
   // Command and control pins
   input wire logic i_cke,
   input wire logic i_odt,
   input wire dd2_pkg::dd2_pins_t i_pins,
   // Data pins, strobes and masks
   input wire dd2_pkg::dd2_pair_t i_dq,
   input wire dd2_pkg::dd2_mask_t i_dm,
   input wire logic [1:0] i_dqs,
   output var dd2_pkg::dd2_pair_t o_dq,
   output logic o_dq_oe,
   output logic [1:0] o_dqs,
   output logic [1:0] o_dqs_oe,
   output logic [1:0] o_dqs_n,
   output logic [1:0] o_dqs_n_oe,
   output logic o_term_on,
   // Status in the i_clock domain
   output var dd2_pkg::dd2_status_t o_status
);

   localparam int LAT_SLOTS = `DD2_LAT_SLOTS;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic dd2_pkg::dd2_cmd_t decode(input dd2_pkg::dd2_pins_t p);
      dd2_pkg::dd2_cmd_t c;
      c = dd2_pkg::cmd_nop;
      if (!p.cs_n) begin
         case ({p.ras_n, p.cas_n, p.we_n})
            3'h0: c = dd2_pkg::cmd_mode_set;
            3'h1: c = dd2_pkg::cmd_refresh;
            3'h2: c = dd2_pkg::cmd_precharge;
            3'h3: c = dd2_pkg::cmd_activate;
            3'h4: c = dd2_pkg::cmd_write;
            3'h5: c = dd2_pkg::cmd_read;
            default: c = dd2_pkg::cmd_nop;
         endcase
      end
      return c;
   endfunction

   // Column of a beat within the burst
   function automatic logic [9:0] beat_col(input logic [9:0] col,
         input logic [2:0] beat, input logic bl8, input logic ilv);
      logic [2:0] ofs;
      ofs = ilv ? (col[2:0] ^ beat) : 3'(col[2:0] + beat);
      if (bl8) begin
         return {col[9:3], ofs};
      end
      return {col[9:2], ofs[1:0]};
   endfunction

   // Array word of a bank, row and column
   function automatic logic [MEM_AW-1:0] mem_index(input logic [2:0] bank,
         input logic [12:0] row, input logic [9:0] col);
      logic [25:0] full;
      full = {row, bank, col};
      return full[MEM_AW-1:0];
   endfunction

   // ----------------------------------------------------------------
   // Command acceptance
   // ----------------------------------------------------------------
   logic cke_q;
   logic sr_q;
   dd2_pkg::dd2_pwr_t pwr_q;
   dd2_pkg::dd2_cmd_t cmd;
   dd2_pkg::dd2_cmd_t raw_cmd;
   logic accept;
   logic sr_enter;
   logic [7:0] open_q;
   logic [12:0] row_q [8];

   assign raw_cmd = decode(i_pins);
   // Command pins are ignored while powered down or in self-refresh
   assign accept = cke_q && i_cke && !sr_q && pwr_q == dd2_pkg::pwr_run;
   assign cmd = accept ? raw_cmd : dd2_pkg::cmd_nop;
   assign sr_enter = cke_q && !i_cke && !sr_q && open_q == 8'h00 &&
      pwr_q == dd2_pkg::pwr_run && raw_cmd == dd2_pkg::cmd_refresh;

   always_ff @(posedge i_ck or negedge i_rstn) begin
      if (!i_rstn) begin
         cke_q <= 1'b0;
      end else begin
         cke_q <= i_cke;
      end
   end

   // ----------------------------------------------------------------
   // Mode registers
   // ----------------------------------------------------------------
   logic bl8_q;
   logic ilv_q;
   logic [2:0] cl_q;
   logic [2:0] al_q;
   logic rtt_en_q;
   logic strobe_se_q;
   logic [12:0] op;

   assign op = i_pins.addr;

   always_ff @(posedge i_ck or negedge i_rstn) begin
      if (!i_rstn) begin
         bl8_q <= 1'b0;
         ilv_q <= 1'b0;
         cl_q <= `DD2_CL_RST;
         al_q <= `DD2_AL_RST;
         rtt_en_q <= 1'b0;
         strobe_se_q <= 1'b0;
      end else if (cmd == dd2_pkg::cmd_mode_set) begin
         if (i_pins.ba == `DD2_BA_BASE) begin
            // Unsupported codes leave the previous setting in force
            if (op[`DD2_BL_LSB +: 3] == `DD2_BL_CODE4) begin
               bl8_q <= 1'b0;
            end else if (op[`DD2_BL_LSB +: 3] == `DD2_BL_CODE8) begin
               bl8_q <= 1'b1;
            end
            ilv_q <= op[`DD2_BT_BIT];
            if (op[`DD2_CL_LSB +: 3] >= `DD2_CL_MIN &&
                  op[`DD2_CL_LSB +: 3] <= `DD2_CL_MAX) begin
               cl_q <= op[`DD2_CL_LSB +: 3];
            end
         end else if (i_pins.ba == `DD2_BA_EXT1) begin
            if (op[`DD2_AL_LSB +: 3] <= `DD2_AL_MAX) begin
               al_q <= op[`DD2_AL_LSB +: 3];
            end
            rtt_en_q <= op[`DD2_RTT0_BIT] | op[`DD2_RTT1_BIT];
            strobe_se_q <= op[`DD2_STROBE_SE_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Bank state
   // ----------------------------------------------------------------
   always_ff @(posedge i_ck or negedge i_rstn) begin
      if (!i_rstn) begin
         open_q <= 8'h00;
         for (int b = 0; b < 8; b++) begin
            row_q[b] <= 13'h0000;
         end
      end else begin
         unique case (cmd)
            dd2_pkg::cmd_activate: begin
               open_q[i_pins.ba] <= 1'b1;
               row_q[i_pins.ba] <= i_pins.addr;
            end
            dd2_pkg::cmd_precharge: begin
               if (i_pins.addr[`DD2_AUTO_PRE_BIT]) begin
                  open_q <= 8'h00;
               end else begin
                  open_q[i_pins.ba] <= 1'b0;
               end
            end
            dd2_pkg::cmd_read, dd2_pkg::cmd_write: begin
               // Auto-precharge closes the bank once the access is taken
               if (i_pins.addr[`DD2_AUTO_PRE_BIT]) begin
                  open_q[i_pins.ba] <= 1'b0;
               end
            end
            dd2_pkg::cmd_nop, dd2_pkg::cmd_mode_set,
            dd2_pkg::cmd_refresh: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Power modes
   // ----------------------------------------------------------------
   // A burst in flight runs on if CKE drops; holding CKE is the host's duty
   always_ff @(posedge i_ck or negedge i_rstn) begin
      if (!i_rstn) begin
         pwr_q <= dd2_pkg::pwr_run;
      end else begin
         unique case (pwr_q)
            dd2_pkg::pwr_run: begin
               if (cke_q && !i_cke && !sr_q && !sr_enter) begin
                  pwr_q <= (open_q != 8'h00) ? dd2_pkg::pwr_act_down
                     : dd2_pkg::pwr_pre_down;
               end
            end
            dd2_pkg::pwr_pre_down, dd2_pkg::pwr_act_down: begin
               if (i_cke) begin
                  pwr_q <= dd2_pkg::pwr_run;
               end
            end
            default: pwr_q <= dd2_pkg::pwr_run;
         endcase
      end
   end

   // CK may stop in self-refresh, so CKE high leaves it without a clock
   always_ff @(posedge i_ck or negedge i_rstn or posedge i_cke) begin
      if (!i_rstn) begin
         sr_q <= 1'b0;
      end else if (i_cke) begin
         sr_q <= 1'b0;
      end else if (sr_enter) begin
         sr_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Latency pipeline
   // ----------------------------------------------------------------
   dd2_pkg::dd2_slot_t slot_q [LAT_SLOTS];
   dd2_pkg::dd2_slot_t new_slot;
   logic col_cmd;
   logic [3:0] lat_idx;

   assign col_cmd = cmd == dd2_pkg::cmd_read || cmd == dd2_pkg::cmd_write;
   // Slot 0 is used one edge after it is reached, hence the minus one
   assign lat_idx = 4'({1'b0, al_q} + {1'b0, cl_q} - 4'h1);
   always_comb begin
      new_slot.valid = col_cmd;
      new_slot.is_write = cmd == dd2_pkg::cmd_write;
      new_slot.bank = i_pins.ba;
      new_slot.row = row_q[i_pins.ba];
      new_slot.col = i_pins.addr[9:0];
   end

   // Writes share the read delay: data sampled one edge after WL
   always_ff @(posedge i_ck or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int k = 0; k < LAT_SLOTS; k++) begin
            slot_q[k] <= '0;
         end
      end else begin
         for (int k = 0; k < LAT_SLOTS - 1; k++) begin
            slot_q[k] <= (col_cmd && lat_idx == 4'(k)) ? new_slot
               : slot_q[k + 1];
         end
         slot_q[LAT_SLOTS - 1] <=
            (col_cmd && lat_idx == 4'(LAT_SLOTS - 1)) ? new_slot : '0;
      end
   end

   // ----------------------------------------------------------------
   // Burst engine
   // ----------------------------------------------------------------
   dd2_pkg::dd2_slot_t bst_q;
   dd2_pkg::dd2_slot_t cur;
   logic bst_act_q;
   logic [1:0] bst_pair_q;
   logic [1:0] cur_pair;
   logic cur_on;
   logic last;
   logic [MEM_AW-1:0] idx_rise;
   logic [MEM_AW-1:0] idx_fall;
   logic [15:0] mem [2**MEM_AW];

   assign cur = slot_q[0].valid ? slot_q[0] : bst_q;
   assign cur_pair = slot_q[0].valid ? 2'h0 : bst_pair_q;
   assign cur_on = slot_q[0].valid || bst_act_q;
   assign last = bl8_q ? cur_pair == 2'h3 : cur_pair == 2'h1;
   assign idx_rise = mem_index(cur.bank, cur.row,
      beat_col(cur.col, {cur_pair, 1'b0}, bl8_q, ilv_q));
   assign idx_fall = mem_index(cur.bank, cur.row,
      beat_col(cur.col, {cur_pair, 1'b1}, bl8_q, ilv_q));

   always_ff @(posedge i_ck or negedge i_rstn) begin
      if (!i_rstn) begin
         bst_q <= '0;
         bst_act_q <= 1'b0;
         bst_pair_q <= 2'h0;
      end else begin
         bst_q <= cur;
         bst_act_q <= cur_on && !last;
         bst_pair_q <= 2'(cur_pair + 2'h1);
      end
   end

   // Masked or unstrobed bytes are left untouched
   always_ff @(posedge i_ck) begin
      if (cur_on && cur.is_write) begin
         for (int b = 0; b < 2; b++) begin
            if (!i_dm.rise[b] && i_dqs[b]) begin
               mem[idx_rise][8*b +: 8] <= i_dq.rise[8*b +: 8];
            end
            if (!i_dm.fall[b] && i_dqs[b]) begin
               mem[idx_fall][8*b +: 8] <= i_dq.fall[8*b +: 8];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read drivers and termination
   // ----------------------------------------------------------------
   logic rd_on;

   assign rd_on = cur_on && !cur.is_write;

   always_ff @(posedge i_ck or negedge i_rstn) begin
      if (!i_rstn) begin
         o_dq <= '0;
         o_dq_oe <= 1'b0;
         o_dqs <= 2'h0;
         o_dqs_oe <= 2'h0;
         o_dqs_n <= 2'h0;
         o_dqs_n_oe <= 2'h0;
      end else begin
         o_dq.rise <= rd_on ? mem[idx_rise] : 16'h0000;
         o_dq.fall <= rd_on ? mem[idx_fall] : 16'h0000;
         o_dq_oe <= rd_on;
         // Strobe high in the rising half, edge-aligned with the data
         o_dqs <= {2{rd_on}};
         o_dqs_oe <= {2{rd_on}};
         o_dqs_n <= 2'h0;
         o_dqs_n_oe <= {2{rd_on && !strobe_se_q}};
      end
   end

   always_ff @(posedge i_ck or negedge i_rstn) begin
      if (!i_rstn) begin
         o_term_on <= 1'b0;
      end else begin
         o_term_on <= i_odt && rtt_en_q && !sr_q;
      end
   end

   // ----------------------------------------------------------------
   // Status crossing into i_clock
   // ----------------------------------------------------------------
   dd2_pkg::dd2_status_t stat_q;
   dd2_pkg::dd2_status_t stat_meta_q;

   // Each field is an independent level, so bitwise sync is safe
   always_ff @(posedge i_ck or negedge i_rstn) begin
      if (!i_rstn) begin
         stat_q <= '0;
      end else begin
         stat_q.pre_down <= pwr_q == dd2_pkg::pwr_pre_down;
         stat_q.act_down <= pwr_q == dd2_pkg::pwr_act_down;
         stat_q.self_ref <= sr_q;
         stat_q.banks_open <= open_q;
         stat_q.term_on <= i_odt && rtt_en_q && !sr_q;
         stat_q.diff_strobe <= !strobe_se_q;
         stat_q.burst_busy <= cur_on;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         stat_meta_q <= '0;
         o_status <= '0;
      end else begin
         stat_meta_q <= stat_q;
         o_status <= stat_meta_q;
      end
   end

endmodule // dd2_device

`default_nettype wire

// file: verif/dd2_device_props.sv
// Purpose: Concurrent checks on the device pins and status.
// Assumes: Bound to dd2_device; sees only its ports.
// Notes: Read acceptance is rebuilt from the command pins.
`timescale 1ns/1ps
`default_nettype none

module dd2_device_props (
   // Clocks and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_ck,
   // Command pins
   input wire logic i_cke,
   input wire logic i_odt,
   input wire dd2_pkg::dd2_pins_t i_pins,
   // Outputs
   input wire logic o_dq_oe,
   input wire logic [1:0] o_dqs,
   input wire logic [1:0] o_dqs_oe,
   input wire logic [1:0] o_dqs_n,
   input wire logic [1:0] o_dqs_n_oe,
   input wire logic o_term_on,
   input wire dd2_pkg::dd2_status_t o_status
);
   logic cke_q;
   logic rd_now;
   logic [11:0] rd_hist_q;

   // ------------------------------------------------------------
   // Read commands accepted at each link edge
   // ------------------------------------------------------------
   assign rd_now = cke_q && i_cke && !i_pins.cs_n && i_pins.ras_n &&
      !i_pins.cas_n && i_pins.we_n;

   always_ff @(posedge i_ck or negedge i_rstn) begin
      if (!i_rstn) begin
         cke_q <= 1'b0;
         rd_hist_q <= '0;
      end else begin
         cke_q <= i_cke;
         rd_hist_q <= {rd_hist_q[10:0], rd_now};
      end
   end

   chk_read_delay: assert property (@(posedge i_ck) disable iff (!i_rstn)
      rd_now |-> ##[6:12] o_dq_oe)
      else $error("read data did not start in time");
   chk_read_cause: assert property (@(posedge i_ck) disable iff (!i_rstn)
      $rose(o_dq_oe) |-> |rd_hist_q[11:5])
      else $error("read data without an accepted read");
   chk_burst_min: assert property (@(posedge i_ck) disable iff (!i_rstn)
      $rose(o_dq_oe) |-> o_dq_oe [*2])
      else $error("read burst shorter than four beats");
   chk_strobe_read: assert property (@(posedge i_ck) disable iff (!i_rstn)
      o_dq_oe |-> o_dqs_oe == 2'b11 && o_dqs == 2'b11)
      else $error("strobes not driven with read data");
   chk_strobe_idle: assert property (@(posedge i_ck) disable iff (!i_rstn)
      !o_dq_oe |-> o_dqs_oe == 2'b00 && o_dqs_n_oe == 2'b00)
      else $error("strobes driven outside a read");
   chk_diff_strobe: assert property (@(posedge i_ck) disable iff (!i_rstn)
      o_dqs_n_oe != 2'b00 |-> o_dqs_n_oe == 2'b11 && o_dqs_n == 2'b00)
      else $error("complementary strobes wrong");
   chk_term_follow: assert property (@(posedge i_ck) disable iff (!i_rstn)
      !$past(i_odt) |-> !o_term_on)
      else $error("termination on without request");
   chk_pwr_onehot: assert property (@(posedge i_clock) disable iff (!i_rstn)
      $onehot0({o_status.pre_down, o_status.act_down, o_status.self_ref}))
      else $error("more than one power state");
endmodule // dd2_device_props

bind dd2_device dd2_device_props chk (.i_clock, .i_rstn, .i_ck, .i_cke,
   .i_odt, .i_pins, .o_dq_oe, .o_dqs, .o_dqs_oe, .o_dqs_n, .o_dqs_n_oe,
   .o_term_on, .o_status);

`default_nettype wire

// file: verif/dd2_host.sv
// Purpose: Host controller model driving the device pins.
// Assumes: Drives after rising i_ck; read data taken at falling i_ck.
// Notes: Released lines show the inverse of their last value, except chip select, which goes high.
`timescale 1ns/1ps
`default_nettype none

module dd2_host (
   // Link clock
   input wire logic i_ck,
   // Device pins
   output logic o_cke,
   output logic o_odt,
   output var dd2_pkg::dd2_pins_t o_pins,
   output var dd2_pkg::dd2_pair_t o_dq,
   output var dd2_pkg::dd2_mask_t o_dm,
   output logic [1:0] o_dqs,
   input wire dd2_pkg::dd2_pair_t i_dq,
   input wire logic i_dq_oe
);
   logic [15:0] q[8];
   logic early_oe;

   initial begin
      o_cke = 1'b0;
      o_odt = 1'b0;
      o_pins = '1;
      o_dq = '0;
      o_dm = '0;
      o_dqs = '0;
   end

   // Command {cs_n,ras_n,cas_n,we_n}; returns at its sampling edge
   task automatic cmd(input logic [3:0] c, input logic [2:0] ba,
         input logic [12:0] a);
      @(posedge i_ck);
      o_pins <= {c, ba, a};
      @(posedge i_ck);
      o_pins <= {1'b1, ~c[2:0], ~ba, ~a};
   endtask

   // CKE and ODT stay put during every burst
   task automatic ctl(input logic e, input logic t,
         input logic [3:0] c = 4'b1111);
      @(posedge i_ck);
      o_cke <= e;
      o_odt <= t;
      o_pins <= {c, ~o_pins[15:0]};
   endtask

   task automatic wr(input logic [2:0] ba, input logic [9:0] col,
         input int rl, input int n, input logic [15:0] d[8],
         input logic [1:0] m[8]);
      cmd(4'b0100, ba, {3'b000, col});
      repeat (rl - 1) @(posedge i_ck);
      for (int k = 0; k < n; k += 2) begin
         o_dq <= {d[k], d[k+1]};
         o_dm <= {m[k], m[k+1]};
         o_dqs <= 2'b11;
         @(posedge i_ck);
      end
      o_dq <= ~o_dq;
      o_dm <= ~o_dm;
      o_dqs <= 2'b00;
   endtask

   task automatic rd(input logic [2:0] ba, input logic [9:0] col,
         input int rl, input int n, input logic [3:0] c = 4'b0101);
      cmd(c, ba, {3'b000, col});
      repeat (rl - 1) @(posedge i_ck);
      @(negedge i_ck);
      early_oe = i_dq_oe;
      for (int k = 0; k < n; k += 2) begin
         @(negedge i_ck);
         {q[k], q[k+1]} = i_dq;
      end
   endtask
endmodule // dd2_host

`default_nettype wire

// file: verif/dd2_device_bench.sv
// Purpose: Self-checking bench of the device command interface.
// Assumes: Host model drives all pins; link clock runs at 64 ns.
// Notes: Written blocks start on aligned columns.
`timescale 1ns/1ps
`default_nettype none

module dd2_device_bench;
   logic clock = 1'b0;
   logic ck = 1'b0;
   logic rstn = 1'b0;
   logic cke, odt, dq_oe, term;
   dd2_pkg::dd2_pins_t pins;
   dd2_pkg::dd2_pair_t dq_w, dq_r;
   dd2_pkg::dd2_mask_t dm;
   logic [1:0] dqs, dqs_o, dqs_oe, dqsn, dqsn_oe, seen_n;
   dd2_pkg::dd2_status_t st;
   int mismatches = 0;
   int tests_run = 0;
   logic [15:0] d[8], f[8];
   logic [1:0] m[8];

   always #2.5 clock = ~clock;
   initial begin
      #1.1;
      forever #32 ck = ~ck;
   end
   always @(negedge ck) begin
      if (dq_oe) seen_n = dqsn_oe;
   end

   dd2_host host (.i_ck(ck), .o_cke(cke), .o_odt(odt), .o_pins(pins),
      .o_dq(dq_w), .o_dm(dm), .o_dqs(dqs), .i_dq(dq_r), .i_dq_oe(dq_oe));
   dd2_device #(.MEM_AW(14)) uut (.i_clock(clock), .i_rstn(rstn),
      .i_ck(ck), .i_cke(cke), .i_odt(odt), .i_pins(pins), .i_dq(dq_w),
      .i_dm(dm), .i_dqs(dqs), .o_dq(dq_r), .o_dq_oe(dq_oe),
      .o_dqs(dqs_o), .o_dqs_oe(dqs_oe), .o_dqs_n(dqsn),
      .o_dqs_n_oe(dqsn_oe), .o_term_on(term), .o_status(st));

   task automatic check(input logic [63:0] s, input logic [63:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("FAIL at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic fill(input logic [15:0] b);
      for (int k = 0; k < 8; k++) begin
         d[k] = b + 16'(k);
         m[k] = 2'b00;
      end
   endtask

   task automatic mrs(input logic [2:0] ba, input logic [12:0] a);
      host.cmd(4'b0000, ba, a);
   endtask

   // Expected beats follow the burst order inside the aligned block
   task automatic rdchk(input logic [2:0] ba, input logic [9:0] c,
         input int rl, input int n, input bit ilv);
      int a;
      host.rd(ba, c, rl, n);
      check(host.early_oe, 1'b0);
      check(st.burst_busy, 1'b1);
      for (int k = 0; k < n; k++) begin
         a = ilv ? (int'(c) ^ k) : (int'(c) + k);
         check(host.q[k], d[a % n]);
      end
   endtask

   initial begin
      repeat (4) @(posedge ck);
      rstn <= 1'b1;
      @(negedge ck);
      check({dq_r, dq_oe, term, st}, 64'h0000_0000_0000_0000);
      host.ctl(1'b1, 1'b0);
      host.cmd(4'b0011, 3'h3, 13'h0123);
      fill(16'ha000);
      host.wr(3'h3, 10'h004, 5, 4, d, m);
      rdchk(3'h3, 10'h005, 5, 4, 0);
      check(seen_n, 2'b11);
      mrs(3'h0, 13'h005a);
      rdchk(3'h3, 10'h005, 5, 4, 1);
      for (int cl = 5; cl <= 6; cl++) begin
         for (int al = 0; al <= 5; al++) begin
            mrs(3'h0, {6'h00, 3'(cl), 1'b0, 3'h2});
            mrs(3'h1, {7'h00, 3'(al), 3'h0});
            rdchk(3'h3, 10'h006, cl + al, 4, 0);
         end
      end
      fill(16'hb000);
      host.wr(3'h3, 10'h004, 11, 4, d, m);
      rdchk(3'h3, 10'h007, 11, 4, 0);
      mrs(3'h1, 13'h0000);
      mrs(3'h0, 13'h0053);
      fill(16'h8000);
      host.wr(3'h3, 10'h008, 5, 8, d, m);
      rdchk(3'h3, 10'h00a, 5, 8, 0);
      mrs(3'h0, 13'h005b);
      rdchk(3'h3, 10'h00d, 5, 8, 1);
      mrs(3'h0, 13'h0052);
      fill(16'hc000);
      host.wr(3'h3, 10'h004, 5, 4, d, m);
      m[1] = 2'b01;
      m[2] = 2'b10;
      for (int k = 0; k < 8; k++) f[k] = ~d[k];
      host.wr(3'h3, 10'h004, 5, 4, f, m);
      for (int k = 0; k < 4; k++) d[k] ^= ~{{8{m[k][1]}}, {8{m[k][0]}}};
      rdchk(3'h3, 10'h004, 5, 4, 0);
      fill(16'hc000);
      host.cmd(4'b0011, 3'h5, 13'h0042);
      host.wr(3'h5, 10'h004, 5, 4, f, m);
      for (int k = 0; k < 4; k++) d[k] = f[k];
      d[1] ^= 16'h00ff;
      d[2] ^= 16'hff00;
      rdchk(3'h3, 10'h004, 5, 4, 0);
      host.rd(3'h3, 10'h004, 5, 4, 4'b1101);
      check({host.early_oe, host.q[0], host.q[1]}, 33'h0);
      host.cmd(4'b0011, 3'h1, 13'h0000);
      host.cmd(4'b0100, 3'h1, 13'h0400);
      repeat (2) @(posedge ck);
      check(st.banks_open, 8'h28);
      host.cmd(4'b0010, 3'h3, 13'h0000);
      repeat (2) @(posedge ck);
      check(st.banks_open, 8'h20);
      host.cmd(4'b0010, 3'h3, 13'h0400);
      repeat (2) @(posedge ck);
      check(st.banks_open, 8'h00);
      host.cmd(4'b0001, 3'h0, 13'h0000);
      mrs(3'h1, 13'h0400);
      rdchk(3'h3, 10'h004, 5, 4, 0);
      check({seen_n, st.diff_strobe}, 3'b000);
      host.ctl(1'b1, 1'b1);
      repeat (2) @(posedge ck);
      check(term, 1'b0);
      mrs(3'h1, 13'h0004);
      repeat (2) @(posedge ck);
      check({term, st.term_on, st.diff_strobe}, 3'b111);
      host.ctl(1'b0, 1'b1);
      host.cmd(4'b0011, 3'h1, 13'h0000);
      repeat (2) @(posedge ck);
      check({st.pre_down, st.act_down, st.self_ref, term}, 4'b1001);
      host.ctl(1'b1, 1'b1);
      repeat (3) @(posedge ck);
      check({st.pre_down, st.banks_open}, 9'h000);
      host.cmd(4'b0011, 3'h2, 13'h0001);
      host.ctl(1'b0, 1'b1);
      repeat (3) @(posedge ck);
      check({st.act_down, st.banks_open}, 9'h104);
      host.ctl(1'b1, 1'b1);
      host.cmd(4'b0010, 3'h0, 13'h0400);
      host.ctl(1'b0, 1'b1, 4'b0001);
      repeat (3) @(posedge ck);
      check({st.pre_down, st.self_ref, term}, 3'b010);
      host.ctl(1'b1, 1'b0);
      repeat (2) @(posedge ck);
      check({st.pre_down, st.act_down, st.self_ref}, 3'b000);
      complete_run();
   end

   initial begin
      repeat (4000) @(posedge ck);
      mismatches++;
      complete_run();
   end
endmodule // dd2_device_bench

`default_nettype wire
